// ### core/sew_core.sv
// serial eeprom core: link-side command decoder plus system-side array and programming
`timescale 1ns/10ps
`include "sew_regs.svh"
module sew_core #(
    parameter int unsigned PROG_CYCLES = `SEW_PROG_CYCLES // programming interval in cycles
) (
    input  wire logic clk_sys_in,        // system clock, 100 MHz
    input  wire logic rst_n_in,          // async reset, acts as power-up clear
    input  wire logic serial_clock_in,   // host serial clock, link domain
    input  wire logic select_in,         // host select, low = standby
    input  wire logic serial_in,         // host serial data
    output logic      serial_out_out,    // read data or busy/ready level
    output logic      serial_out_oe_out, // high while the output is driven
    output logic      busy_out           // internal programming in progress
);

    // ---- link domain: runs only on host clock edges ----
    // select low holds the decoder in reset, so a dropped frame leaves nothing
    logic link_rst_n;
    assign link_rst_n = rst_n_in & select_in;

    sew_pkg::sew_lstate_t    lst_r;       // decoder state
    sew_pkg::sew_lstate_t    lst_nxt;
    logic [`SEW_CNT_W-1:0]   cnt_r;       // bit counter within a field
    logic [`SEW_CNT_W-1:0]   cnt_nxt;
    logic [`SEW_OP_W-1:0]    op_r;        // opcode shift register
    logic [6:0]              addr_sh_r;   // upper seven address bits
    logic [14:0]             data_sh_r;   // upper fifteen data bits
    logic [`SEW_DATA_W-1:0]  rd_sh_r;     // outgoing read word
    logic                    rd_act_r;    // read phase owns the output
    logic                    rd_bit_r;    // current read output bit
    logic                    in_cmd_r;    // a start bit has been taken
    logic [2:0]              rdy_cnt_r;   // clocks seen while ready shown
    logic                    busy_l1_r;   // busy sync, first stage
    logic                    busy_l2_r;   // busy sync, second stage
    logic                    rdy_l1_r;    // ready sync, first stage
    logic                    rdy_l2_r;    // ready sync, second stage
    logic                    status_rdy_r; // ready level being shown, system domain
    // these survive select low: the system side reads them after the fall
    sew_pkg::sew_cmd_t       cmd_r;       // last decoded command
    logic                    cmd_tgl_r;   // flips once per completed command
    logic [`SEW_ADDR_W-1:0]  rd_addr_r;   // address of the word being fetched
    logic                    rd_tgl_r;    // flips once per fetch request
    logic [`SEW_DATA_W-1:0]  rd_word_r;   // fetched word, system domain

    // decode of the current bit position
    logic [`SEW_ADDR_W-1:0]  addr_full;
    logic [1:0]              ext_sel;
    sew_pkg::sew_kind_t      ext_kind;
    sew_pkg::sew_kind_t      addr_kind;
    logic                    forced_start;
    logic                    start_seen;
    logic                    op_done;
    logic                    addr_done;
    logic                    data_done;
    logic                    word_edge;
    logic                    is_read;
    logic                    needs_data;
    logic                    issue_now;

    assign addr_full    = {addr_sh_r, serial_in};
    assign ext_sel      = addr_sh_r[6:5]; // top two address bits pick the extended command
    assign ext_kind     = (ext_sel == `SEW_EXT_LOCK) ? sew_pkg::K_LOCK :
                          (ext_sel == `SEW_EXT_FILL) ? sew_pkg::K_FILL :
                          (ext_sel == `SEW_EXT_ERAL) ? sew_pkg::K_ERAL : sew_pkg::K_UNLOCK;
    assign addr_kind    = (op_r == `SEW_OP_READ)  ? sew_pkg::K_READ  :
                          (op_r == `SEW_OP_WRITE) ? sew_pkg::K_WRITE :
                          (op_r == `SEW_OP_ERASE) ? sew_pkg::K_ERASE : ext_kind;
    // a ready level held past four clocks is read back as a start bit
    assign forced_start = rdy_l2_r && (rdy_cnt_r == `SEW_READY_CLKS);
    // busy blocks a start from the third clock of a frame on; otherwise the first one is the start bit
    assign start_seen   = (lst_r == sew_pkg::L_IDLE) && !busy_l2_r
                          && (serial_in || forced_start);
    assign op_done      = (lst_r == sew_pkg::L_OP) && (cnt_r == `SEW_OP_LAST);
    assign addr_done    = (lst_r == sew_pkg::L_ADDR) && (cnt_r == `SEW_ADDR_LAST);
    assign data_done    = (lst_r == sew_pkg::L_DATA) && (cnt_r == `SEW_DATA_LAST);
    assign word_edge    = (lst_r == sew_pkg::L_READ) && (cnt_r == '0);
    assign is_read      = (addr_kind == sew_pkg::K_READ);
    assign needs_data   = (addr_kind == sew_pkg::K_WRITE) || (addr_kind == sew_pkg::K_FILL);
    // commands other than read without a data field complete on the last address bit
    assign issue_now    = (addr_done && !is_read && !needs_data) || data_done;

    // decoder next state
    always_comb
    begin
        lst_nxt = lst_r;
        cnt_nxt = cnt_r + 4'h1;
        case (lst_r)
            sew_pkg::L_IDLE:
            begin
                cnt_nxt = '0;
                if (start_seen)
                    lst_nxt = sew_pkg::L_OP;
            end
            sew_pkg::L_OP:
            begin
                if (op_done)
                begin
                    lst_nxt = sew_pkg::L_ADDR;
                    cnt_nxt = '0;
                end
            end
            sew_pkg::L_ADDR:
            begin
                if (addr_done)
                begin
                    cnt_nxt = '0;
                    if (is_read)
                        lst_nxt = sew_pkg::L_READ;
                    else if (needs_data)
                        lst_nxt = sew_pkg::L_DATA;
                    else
                        lst_nxt = sew_pkg::L_DONE;
                end
            end
            sew_pkg::L_DATA:
            begin
                if (data_done)
                    lst_nxt = sew_pkg::L_DONE;
            end
            sew_pkg::L_READ:
            begin
                cnt_nxt = cnt_r + 4'h1; // wraps every sixteen bits
            end
            sew_pkg::L_DONE:
            begin
                cnt_nxt = cnt_r; // extra clocks are ignored until select falls
            end
            default:
            begin
                lst_nxt = sew_pkg::L_IDLE;
            end
        endcase
    end

    // frame state; all sampling on rising serial clock edges
    always_ff @(posedge serial_clock_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            lst_r     <= sew_pkg::L_IDLE;
            cnt_r     <= '0;
            op_r      <= '0;
            addr_sh_r <= '0;
            data_sh_r <= '0;
            in_cmd_r  <= 1'b0;
        end
        else
        begin
            lst_r     <= lst_nxt;
            cnt_r     <= cnt_nxt;
            in_cmd_r  <= in_cmd_r | start_seen;
            if (lst_r == sew_pkg::L_OP)
                op_r <= {op_r[0], serial_in};
            if (lst_r == sew_pkg::L_ADDR)
                addr_sh_r <= {addr_sh_r[5:0], serial_in};
            if (lst_r == sew_pkg::L_DATA)
                data_sh_r <= {data_sh_r[13:0], serial_in};
        end
    end

    // read output shifter; changes only on rising edges
    always_ff @(posedge serial_clock_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rd_act_r <= 1'b0;
            rd_bit_r <= 1'b0;
            rd_sh_r  <= '0;
        end
        else if (addr_done && is_read)
        begin
            rd_act_r <= 1'b1;
            rd_bit_r <= `SEW_DUMMY_BIT;
        end
        else if (word_edge)
        begin
            // the fetch was requested a full clock earlier, so the word is settled
            rd_bit_r <= rd_word_r[`SEW_DATA_W-1];
            rd_sh_r  <= {rd_word_r[`SEW_DATA_W-2:0], 1'b0};
        end
        else if (lst_r == sew_pkg::L_READ)
        begin
            rd_bit_r <= rd_sh_r[`SEW_DATA_W-1];
            rd_sh_r  <= {rd_sh_r[`SEW_DATA_W-2:0], 1'b0};
        end
    end

    // status levels from the system side, two stages each
    always_ff @(posedge serial_clock_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            busy_l1_r <= 1'b0;
            busy_l2_r <= 1'b0;
            rdy_l1_r  <= 1'b0;
            rdy_l2_r  <= 1'b0;
            rdy_cnt_r <= '0;
        end
        else
        begin
            busy_l1_r <= busy_out;
            busy_l2_r <= busy_l1_r;
            rdy_l1_r  <= status_rdy_r;
            rdy_l2_r  <= rdy_l1_r;
            // count idle clocks under a ready level, saturating at the limit
            if (rdy_l2_r && lst_r == sew_pkg::L_IDLE && rdy_cnt_r != `SEW_READY_CLKS)
                rdy_cnt_r <= rdy_cnt_r + 3'h1;
        end
    end

    // completed commands and fetch requests; kept across select low
    always_ff @(posedge serial_clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cmd_r     <= '0;
            cmd_tgl_r <= 1'b0;
            rd_addr_r <= '0;
            rd_tgl_r  <= 1'b0;
        end
        else
        begin
            if (addr_done && select_in)
            begin
                cmd_r.kind <= addr_kind;
                cmd_r.addr <= addr_full;
            end
            if (data_done && select_in)
                cmd_r.data <= {data_sh_r, serial_in};
            if (issue_now && select_in)
                cmd_tgl_r <= ~cmd_tgl_r;
            if (addr_done && is_read && select_in)
            begin
                rd_addr_r <= addr_full;
                rd_tgl_r  <= ~rd_tgl_r;
            end
            else if (word_edge && select_in)
            begin
                rd_addr_r <= rd_addr_r + 8'h01;
                rd_tgl_r  <= ~rd_tgl_r;
            end
        end
    end

    // ---- system domain ----
    logic [3:0]              sel_sh_r;     // select sync plus two delay stages
    logic [2:0]              ct_sh_r;      // command toggle sync plus history
    logic [2:0]              rt_sh_r;      // fetch toggle sync plus history
    logic [1:0]              in_cmd_sh_r;  // link frame-active sync
    logic [1:0]              rd_act_sh_r;  // read-phase sync
    logic [1:0]              rd_bit_sh_r;  // read bit sync
    logic                    wr_en_r;      // writes unlocked
    logic                    armed_r;      // write-type command waits for select fall
    sew_pkg::sew_cmd_t       pcmd_r;       // command being programmed
    sew_pkg::sew_pstate_t    pst_r;        // programming state
    sew_pkg::sew_pstate_t    pst_nxt;
    logic [`SEW_TIMER_W-1:0] timer_r;      // cycles left in the interval
    logic [`SEW_ADDR_W-1:0]  fill_addr_r;  // sweep address for whole-array commands
    logic                    status_en_r;  // busy/ready may be shown
    logic                    blk_r;        // start taken while busy: frame is ignored
    logic                    serial_out_r;
    logic                    serial_oe_r;
    logic                    busy_r;
    logic [`SEW_DATA_W-1:0]  mem [0:(1<<`SEW_ADDR_W)-1]; // the array

    logic                    sel_lvl;
    logic                    sel_fall;
    logic                    cmd_new;
    logic                    rd_new;
    logic                    write_type;
    logic                    start;
    logic                    start_all;
    logic                    mem_we;
    logic [`SEW_ADDR_W-1:0]  mem_wa;
    logic [`SEW_DATA_W-1:0]  mem_wd;
    logic                    prog_end;
    logic                    blk;          // current frame is to be ignored
    logic                    rd_show;      // read data owns the output

    // select fall is delayed two extra stages so a command toggle
    // raised on the last clock is always seen first
    assign sel_lvl    = sel_sh_r[1];
    assign sel_fall   = sel_sh_r[3] & ~sel_sh_r[2];
    assign cmd_new    = ct_sh_r[1] ^ ct_sh_r[2];
    assign rd_new     = rt_sh_r[1] ^ rt_sh_r[2];
    assign write_type = (cmd_r.kind == sew_pkg::K_WRITE) || (cmd_r.kind == sew_pkg::K_ERASE)
                        || (cmd_r.kind == sew_pkg::K_FILL) || (cmd_r.kind == sew_pkg::K_ERAL);
    assign start      = (pst_r == sew_pkg::P_IDLE) && armed_r && sel_fall;
    assign start_all  = (pcmd_r.kind == sew_pkg::K_FILL) || (pcmd_r.kind == sew_pkg::K_ERAL);
    assign prog_end   = (pst_r == sew_pkg::P_WAIT) && (timer_r == '0);
    // the link's busy sync restarts with select, so a start bit on either of the first two
    // clocks of a frame slips past it; the frame is discarded here instead
    assign blk        = blk_r | (in_cmd_sh_r[1] & busy_r);
    assign rd_show    = rd_act_sh_r[1] & ~blk;
    assign mem_we     = (start && !start_all) || (pst_r == sew_pkg::P_FILL);
    assign mem_wa     = (pst_r == sew_pkg::P_FILL) ? fill_addr_r : pcmd_r.addr;
    // the new word replaces the old in one step: erase is implied
    assign mem_wd     = ((pcmd_r.kind == sew_pkg::K_ERASE) || (pcmd_r.kind == sew_pkg::K_ERAL))
                        ? `SEW_ERASED_WORD : pcmd_r.data;

    // programming state: nothing on the pins can leave it early
    always_comb
    begin
        pst_nxt = pst_r;
        case (pst_r)
            sew_pkg::P_IDLE:
            begin
                if (start)
                    pst_nxt = start_all ? sew_pkg::P_FILL : sew_pkg::P_WAIT;
            end
            sew_pkg::P_FILL:
            begin
                if (fill_addr_r == `SEW_LAST_ADDR)
                    pst_nxt = sew_pkg::P_WAIT;
            end
            sew_pkg::P_WAIT:
            begin
                if (prog_end)
                    pst_nxt = sew_pkg::P_IDLE;
            end
            default:
            begin
                pst_nxt = sew_pkg::P_IDLE;
            end
        endcase
    end

    // synchronisers: first stage feeds only the second
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sel_sh_r    <= '0;
            ct_sh_r     <= '0;
            rt_sh_r     <= '0;
            in_cmd_sh_r <= '0;
            rd_act_sh_r <= '0;
            rd_bit_sh_r <= '0;
        end
        else
        begin
            sel_sh_r    <= {sel_sh_r[2:0], select_in};
            ct_sh_r     <= {ct_sh_r[1:0], cmd_tgl_r};
            rt_sh_r     <= {rt_sh_r[1:0], rd_tgl_r};
            in_cmd_sh_r <= {in_cmd_sh_r[0], in_cmd_r};
            rd_act_sh_r <= {rd_act_sh_r[0], rd_act_r};
            rd_bit_sh_r <= {rd_bit_sh_r[0], rd_bit_r};
        end
    end

    // lock state and the armed write command
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_en_r <= 1'b0;
            armed_r <= 1'b0;
            pcmd_r  <= '0;
        end
        else
        begin
            if (cmd_new && !blk && cmd_r.kind == sew_pkg::K_LOCK)
                wr_en_r <= 1'b0;
            else if (cmd_new && !blk && cmd_r.kind == sew_pkg::K_UNLOCK)
                wr_en_r <= 1'b1;
            // a locked device never arms, reads are untouched
            if (cmd_new && !blk && write_type && wr_en_r && pst_r == sew_pkg::P_IDLE)
            begin
                armed_r <= 1'b1;
                pcmd_r  <= cmd_r;
            end
            else if (sel_fall)
                armed_r <= 1'b0;
        end
    end

    // interval timer and fill sweep
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pst_r       <= sew_pkg::P_IDLE;
            timer_r     <= '0;
            fill_addr_r <= '0;
            busy_r      <= 1'b0;
        end
        else
        begin
            pst_r  <= pst_nxt;
            busy_r <= (pst_nxt != sew_pkg::P_IDLE);
            if (start)
                timer_r <= `SEW_TIMER_W'(PROG_CYCLES - 1);
            else if (pst_r != sew_pkg::P_IDLE && timer_r != '0)
                timer_r <= timer_r - 24'h000001;
            if (start)
                fill_addr_r <= '0;
            else if (pst_r == sew_pkg::P_FILL)
                fill_addr_r <= fill_addr_r + 8'h01;
        end
    end

    // array write and word fetch for the link
    always_ff @(posedge clk_sys_in)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
        if (rd_new)
            rd_word_r <= mem[rd_addr_r];
    end

    // status window opens at the start of programming and closes once
    // the device is ready and select is low; the opening wins a tie
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            status_en_r  <= 1'b0;
            status_rdy_r <= 1'b0;
            blk_r        <= 1'b0;
        end
        else
        begin
            status_en_r  <= start | (status_en_r & (busy_r | sel_lvl));
            status_rdy_r <= status_en_r & ~busy_r & sel_lvl;
            blk_r        <= blk & sel_lvl; // held until select drops
        end
    end

    // output pin: read data while reading, otherwise busy/ready status
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            serial_out_r <= 1'b0;
            serial_oe_r  <= 1'b0;
        end
        else
        begin
            serial_oe_r  <= sel_lvl & (rd_show
                            | (status_en_r & (~in_cmd_sh_r[1] | blk)));
            serial_out_r <= rd_show ? rd_bit_sh_r[1] : ~busy_r;
        end
    end

    assign serial_out_out    = serial_out_r;
    assign serial_out_oe_out = serial_oe_r;
    assign busy_out          = busy_r;

endmodule

// ### core/sew_pkg.sv
// types shared by the serial eeprom command core
`include "sew_regs.svh"
package sew_pkg;
    typedef enum logic [2:0] {K_NONE, K_READ, K_WRITE, K_ERASE, K_FILL, K_ERAL,
                              K_UNLOCK, K_LOCK} sew_kind_t;
    typedef struct packed {
        sew_kind_t                kind;
        logic [`SEW_ADDR_W-1:0]   addr;
        logic [`SEW_DATA_W-1:0]   data;
    } sew_cmd_t;
    typedef enum logic [2:0] {L_IDLE, L_OP, L_ADDR, L_DATA, L_READ, L_DONE} sew_lstate_t;
    typedef enum logic [1:0] {P_IDLE, P_FILL, P_WAIT} sew_pstate_t;
endpackage

// ### core/sew_regs.svh
// constants, widths and timing counts for the serial eeprom command core
// Operation
// - write takes 8-bit address, 16-bit word
// - commands ignored while status shows busy
// - busy shown only inside programming interval
// - leading zeros skipped, first one starts
// - address auto-increment only while reading
// - select high after write shows busy/ready
// - fill programs every word in one interval
// - power-up and lock command lock writes
// - locked device drops writes, still reads
// - select low aborts a read anywhere
// - select aborts writes before programming only
// - select low clears partial command input
// - select rising with clock high may sample
// - locked after power-up until unlock command
// - dummy zero driven during lowest address bit
// - output carries read data or busy/ready
// - fifth clock after ready is start bit
// - input sampled, read data changed, rising edges
// - unlocked until lock command or power loss
`ifndef SEW_REGS_SVH
`define SEW_REGS_SVH
`define SEW_CLK_MHZ        100
`define SEW_PROG_TIME_MS   10
`define SEW_PROG_CYCLES    (`SEW_PROG_TIME_MS * `SEW_CLK_MHZ * 1000)
`define SEW_TIMER_W        24
`define SEW_ADDR_W         8
`define SEW_DATA_W         16
`define SEW_OP_W           2
`define SEW_CNT_W          4
`define SEW_ADDR_LAST      4'h7
`define SEW_DATA_LAST      4'hF
`define SEW_OP_LAST        4'h1
`define SEW_READY_CLKS     3'h4
`define SEW_ERASED_WORD    16'hFFFF
`define SEW_LAST_ADDR      8'hFF
`define SEW_OP_READ        2'h2
`define SEW_OP_WRITE       2'h1
`define SEW_OP_ERASE       2'h3
`define SEW_OP_EXT         2'h0
`define SEW_EXT_LOCK       2'h0
`define SEW_EXT_FILL       2'h1
`define SEW_EXT_ERAL       2'h2
`define SEW_DUMMY_BIT      1'h0
`endif

// ### tb/serial_eeprom_write_status_ctrl_tb_top.sv
// self-checking bench for the serial eeprom command core
`timescale 1ns/10ps
module serial_eeprom_write_status_ctrl_tb_top;
    localparam int unsigned PC = 1000; // shortened programming interval
    logic        clk_sys_in = 1'h0;
    logic        rst_n_in = 1'h0;
    logic        sclk, sel, sdi, sdo, soe, busy;
    logic [15:0] mem [256]; // expected array content
    int          mismatches = 0;
    int          checks = 0;
    int          seed = 12965;
    int          w;
    logic [7:0]  a;
    logic [15:0] d;
    always #5 clk_sys_in = ~clk_sys_in;
    sew_core #(.PROG_CYCLES(PC)) DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .serial_clock_in(sclk), .select_in(sel), .serial_in(sdi), .serial_out_out(sdo),
        .serial_out_oe_out(soe), .busy_out(busy));
    sew_host_model host (.serial_clock_out(sclk), .select_out(sel), .data_out(sdi),
        .dev_data_in(sdo), .dev_oe_in(soe));
    task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [63:0] ext(input logic [1:0] s); // extended command bits
        return {1'h1, 2'h0, s, 6'h0};
    endfunction
    // read one word: dummy zero then the data
    task automatic rd(input logic [7:0] ad);
        host.frame({1'h1, 2'h2, ad, 17'h0}, 28);
        chk("read", {1'h0, mem[ad]}, host.rx[16:0]);
    endtask
    // write-type frame with leading zeros; busy expected or not
    task automatic wr(input logic [63:0] b, input int n, input bit prog);
        host.frame(b, n);
        chk("busy", {16'h0, prog}, {16'h0, busy});
        if (prog)
            host.poll(w);
        if (prog)
            chk("ready", 17'h1, {16'h0, w > 0 && w < PC});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog: whole sequence needs well under half of this
    initial
    begin
        #1000000;
        mismatches++;
        end_sim();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        #200;
        wr({1'h1, 2'h1, 8'h10, 16'h1234}, 32, 0);
        wr(ext(2'h3), 16, 0);
        d = 16'($random(seed));
        wr({1'h1, 2'h0, 8'h40, d}, 32, 1);
        for (int i = 0; i < 256; i++) mem[i] = d;
        for (int i = 0; i < 3; i++) rd(8'($random(seed)));
        $display("fill done");
        for (int i = 0; i < 6; i++)
        begin
            a = 8'($random(seed));
            d = 16'($random(seed));
            wr({1'h1, 2'h1, a, d}, 32, 1);
            mem[a] = d;
            rd(a);
        end
        host.frame({1'h1, 2'h1, a, ~d}, 27);
        host.frame({1'h1, 2'h2, a, 17'h0}, 28);
        chk("ignored", 17'h0, host.rx[16:0]);
        host.poll(w);
        mem[a] = ~d;
        host.frame({1'h1, 2'h2, 8'hFF, 33'h0}, 44);
        chk("stream", {1'h0, mem[255]}, host.rx[32:16]);
        chk("stream", {1'h0, mem[0]}, {1'h0, host.rx[15:0]});
        $display("write done");
        host.frame({1'h1, 2'h1, a, d} >> 7, 20);
        chk("abort", 17'h0, {16'h0, busy});
        host.frame({1'h1, 2'h2, a}, 14);
        rd(a);
        wr({1'h1, 2'h3, a}, 16, 1);
        mem[a] = 16'hFFFF;
        rd(a);
        wr(ext(2'h0), 16, 0);
        wr({1'h1, 2'h1, a, d}, 32, 0);
        rd(a);
        wr(ext(2'h3), 16, 0);
        wr(ext(2'h2), 16, 1);
        for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
        rd(8'($random(seed)));
        // clocking on past ready: the ready level starts a lock command
        host.frame({1'h1, 2'h1, a, d}, 27);
        chk("busy", 17'h1, {16'h0, busy});
        host.frame(64'h0, 120);
        mem[a] = d;
        wr({1'h1, 2'h1, a, ~d}, 32, 0);
        rd(a);
        wr(ext(2'h0), 16, 0);
        $display("lock and erase done");
        end_sim();
    end
endmodule

// ### tb/sew_core_monitor.sv
// port checker for the serial eeprom command core
`timescale 1ns/10ps
module sew_core_monitor #(
    parameter int unsigned PROG_CYCLES = 1000000 // programming interval in cycles
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic serial_clock_in,
    input wire logic select_in,
    input wire logic serial_in,
    input wire logic serial_out_out,
    input wire logic serial_out_oe_out,
    input wire logic busy_out
);
    logic [31:0] len_r; // cycles the current busy interval has stood
    // length of busy, so a short or overlong interval shows up when busy falls
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
        if (!rst_n_in)
            len_r <= 32'h0;
        else
            len_r <= busy_out ? len_r + 32'h1 : 32'h0;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    property p_oe_idle; (!select_in && !busy_out) [*6] |-> !serial_out_oe_out; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven in standby");
    property p_busy_start; $rose(busy_out) |-> !$past(select_in, 2); endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without select fall");
    property p_busy_len; $fell(busy_out) |-> len_r + 2 >= PROG_CYCLES && len_r <= PROG_CYCLES + 2;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_busy_hold; $rose(busy_out) |-> busy_out [*8]; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy cut short");
    property p_busy_low; (busy_out && serial_out_oe_out) [*4] |-> !serial_out_out; endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy status not low");
    property p_ready; $fell(busy_out) && select_in |-> ##[1:6] serial_out_oe_out && serial_out_out;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not shown");
    property p_oe_busy; (busy_out && select_in) [*6] |-> serial_out_oe_out; endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("status not driven");
    property p_no_late; $rose(select_in) && !busy_out |-> !serial_out_oe_out [*4]; endproperty
    a_no_late: assert property (p_no_late) else $error("status after interval");
    c_busy: cover property ($rose(busy_out));
    c_ready: cover property ($fell(busy_out) && select_in);
    c_read: cover property (serial_out_oe_out && !busy_out);
endmodule
bind sew_core sew_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .serial_clock_in(serial_clock_in), .select_in(select_in),
    .serial_in(serial_in), .serial_out_out(serial_out_out),
    .serial_out_oe_out(serial_out_oe_out), .busy_out(busy_out));

// ### tb/sew_host_model.sv
// host model driving the three-wire command link
`timescale 1ns/10ps
module sew_host_model (
    output logic      serial_clock_out, // link clock, still outside frames
    output logic      select_out,
    output logic      data_out,
    input  wire logic dev_data_in,
    input  wire logic dev_oe_in
);
    logic [63:0] rx; // device output seen just before each rise
    initial {serial_clock_out, select_out, data_out} = 3'h0;
    // one frame, msb first; unset output reads as unknown
    task automatic frame(input logic [63:0] b, input int n);
        select_out <= 1'h1;
        #203;
        for (int i = n - 1; i >= 0; i--)
        begin
            data_out <= b[i];
            #62.5;
            rx = {rx[62:0], dev_oe_in ? dev_data_in : 1'bx};
            serial_clock_out <= 1'h1;
            #62.5;
            serial_clock_out <= 1'h0;
        end
        #125;
        data_out <= 1'h0;
        select_out <= 1'h0;
        #300;
    endtask
    // status poll; drops select as soon as ready shows
    task automatic poll(output int waited);
        select_out <= 1'h1;
        waited = 0;
        while (!(dev_oe_in && dev_data_in) && waited < 3000)
        begin
            #10;
            waited++;
        end
        select_out <= 1'h0;
        #300;
    endtask
endmodule
